// File: inertial_output_data_regs.sv
/*
 * Read-only inertial output data registers: three rate channels and
 * three acceleration channels, each a low and a high 16-bit word.
 * Assumes serial framing logic on the same clock presents byte
 * addresses and takes read data one cycle later.
 */
`timescale 1ns/100ps
`default_nettype none
module inertial_output_data_regs
    import imu_out_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic [CHAN_W-1:0] rate_x_in,
    input wire logic [CHAN_W-1:0] rate_y_in,
    input wire logic [CHAN_W-1:0] rate_z_in,
    input wire logic [CHAN_W-1:0] accel_x_in,
    input wire logic [CHAN_W-1:0] accel_y_in,
    input wire logic [CHAN_W-1:0] accel_z_in,
    input wire logic update_tick,
    input wire logic [1:0] range_sel,
    output logic [7:0] rate_scale,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic rd_valid,
    output logic [WORD_W-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    output logic wr_ignored
);

    // ========================================================
    // helpers
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        addr_hit = (a >= FIRST_ADDR) && (a <= LAST_ADDR);
    endfunction : addr_hit

    // word index: low word of channel k is 2k, high word 2k+1
    function automatic logic [IDX_W-1:0] addr_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - FIRST_ADDR;
        addr_index = off[IDX_W:1];
    endfunction : addr_index

    function automatic logic [7:0] scale_of(input logic [1:0] r);
        logic [7:0] s;
        s = SCALE_2000;
        if (r == RANGE_125)
        begin
            s = SCALE_125;
        end
        else if (r == RANGE_500)
        begin
            s = SCALE_500;
        end
        scale_of = s;
    endfunction : scale_of

    // ========================================================
    // sample buffer
    logic [SAMPLE_W-1:0] fifo_in;
    logic [SAMPLE_W-1:0] fifo_out;
    logic fifo_valid;
    logic load;

    // channel k occupies bits [32k+31:32k], its high word on top
    // words pass unchanged
    assign fifo_in = {accel_z_in, accel_y_in, accel_x_in,
                      rate_z_in, rate_y_in, rate_x_in};

    imu_sample_fifo
    #(
        .WIDTH(SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    )
    u_fifo
    (
        .clock(clock),
        .arst_n(arst_n),
        .ce(ce),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(fifo_in),
        .out_valid(fifo_valid),
        .out_ready(update_tick),
        .out_data(fifo_out)
    );

    // ========================================================
    // output data words
    logic [SAMPLE_W-1:0] sample_q, sample_d;

    always_comb
    begin
        load = ce && update_tick && fifo_valid;
        sample_d = sample_q;
        if (load)
        begin
            sample_d = fifo_out;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sample_q <= SAMPLE_RESET;
        end
        else
        begin
            sample_q <= sample_d;
        end
    end

    // ========================================================
    // read port and write absorption
    logic rd_valid_q, rd_valid_d;
    logic [WORD_W-1:0] rd_data_q, rd_data_d;
    logic [7:0] scale_q, scale_d;

    always_comb
    begin
        rd_valid_d = rd_valid_q;
        rd_data_d = rd_data_q;
        scale_d = scale_q;
        if (ce)
        begin
            rd_valid_d = rd_en;
            scale_d = scale_of(range_sel);
            if (rd_en && addr_hit(rd_addr))
            begin
                rd_data_d = sample_q[addr_index(rd_addr)*WORD_W +: WORD_W];
            end
            else if (rd_en)
            begin
                rd_data_d = UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_valid_q <= 1'b0;
            rd_data_q <= DATA_RESET;
            scale_q <= SCALE_125;
        end
        else
        begin
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
            scale_q <= scale_d;
        end
    end

    assign rd_valid = rd_valid_q;
    assign rd_data = rd_data_q;
    assign rate_scale = scale_q;
    assign wr_ignored = ce && wr_en && addr_hit(wr_addr);

    // ========================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    AST_RATE_X_WORDS: assert property (
        ce && rd_en && (rd_addr == RATE_X_LOW_ADDR || rd_addr == RATE_X_HIGH_ADDR)
        |=> rd_valid && rd_data == ($past(rd_addr) == RATE_X_LOW_ADDR ?
            $past(sample_q[15:0]) : $past(sample_q[31:16])))
        else $error("x rate word read wrong");

    AST_RATE_Y_HIGH: assert property (
        ce && rd_en && rd_addr == RATE_Y_HIGH_ADDR
        |=> rd_data == $past(sample_q[63:48]))
        else $error("y rate high word read wrong");

    AST_RATE_Z_LOW: assert property (
        ce && rd_en && rd_addr == RATE_Z_LOW_ADDR
        |=> rd_data == $past(sample_q[79:64]))
        else $error("z rate low word read wrong");

    AST_RATE_SIGN: assert property (
        ce && rd_en && rd_addr == RATE_Z_HIGH_ADDR
        |=> $signed(rd_data) == $signed($past(sample_q[95:80])))
        else $error("rate high word lost its sign");

    AST_LOW_ODD_BYTE: assert property (
        ce && rd_en && rd_addr == RATE_X_LOW_ADDR + 7'h01
        |=> rd_data == $past(sample_q[15:0]))
        else $error("low word odd byte address mismatch");

    AST_ACCEL_PAIR: assert property (
        ce && rd_en && rd_addr == ACCEL_X_HIGH_ADDR
        |=> rd_data == $past(sample_q[127:112]))
        else $error("accel high word not upper half");

    AST_ACCEL_FS: assert property (
        load && fifo_out[127:112] == ACCEL_POS_FS
        |=> sample_q[127:112] == ACCEL_POS_FS)
        else $error("accel full scale word altered");

    AST_ACCEL_LOW: assert property (
        ce && rd_en && rd_addr == ACCEL_X_LOW_ADDR
        |=> rd_data == $past(sample_q[111:96]))
        else $error("accel low word read wrong");

    AST_ACCEL_Z: assert property (
        ce && rd_en && rd_addr == ACCEL_Z_HIGH_ADDR
        |=> rd_data == $past(sample_q[191:176]))
        else $error("z accel high word read wrong");

    AST_SCALE: assert property (
        ce && range_sel == RANGE_500 |=> rate_scale == SCALE_500)
        else $error("rate scale wrong for range");

    AST_COHERENT: assert property (
        load |=> sample_q == $past(fifo_out))
        else $error("sample words not loaded together");

    AST_WRITE_IGNORED: assert property (
        wr_en && !load |=> $stable(sample_q))
        else $error("write changed output data");

    AST_FREEZE: assert property (
        !ce |=> $stable(rd_data) && $stable(rd_valid) && $stable(sample_q))
        else $error("state moved with clock enable low");

    COV_READ_RATE: cover property (
        load ##2 ce && rd_en && rd_addr == RATE_X_LOW_ADDR);
    COV_FIFO_FULL: cover property (!sample_ready);
    COV_WRITE: cover property (wr_ignored);
    COV_UNMAPPED: cover property (ce && rd_en && !addr_hit(rd_addr));

endmodule : inertial_output_data_regs
`default_nettype wire

// File: imu_out_pkg.sv
/*
 * Constants for the inertial output data registers: byte addresses,
 * word layout, sample packing, rate scale factors and buffer depth.
 * Assumes a byte-addressed register read port driven by serial logic.
 */
package imu_out_pkg;
    localparam int ADDR_W = 7;
    localparam int WORD_W = 16;
    localparam int CHAN_W = 32;
    localparam int NUM_CHAN = 6;
    localparam int NUM_WORDS = 12;
    localparam int SAMPLE_W = NUM_CHAN * CHAN_W;
    localparam int FIFO_DEPTH = 8;
    localparam int IDX_W = 4;

    // ========================================================
    // register byte addresses (each word spans an address pair)
    localparam logic [ADDR_W-1:0] RATE_X_LOW_ADDR = 7'h04;
    localparam logic [ADDR_W-1:0] RATE_X_HIGH_ADDR = 7'h06;
    localparam logic [ADDR_W-1:0] RATE_Y_LOW_ADDR = 7'h08;
    localparam logic [ADDR_W-1:0] RATE_Y_HIGH_ADDR = 7'h0A;
    localparam logic [ADDR_W-1:0] RATE_Z_LOW_ADDR = 7'h0C;
    localparam logic [ADDR_W-1:0] RATE_Z_HIGH_ADDR = 7'h0E;
    localparam logic [ADDR_W-1:0] ACCEL_X_LOW_ADDR = 7'h10;
    localparam logic [ADDR_W-1:0] ACCEL_X_HIGH_ADDR = 7'h12;
    localparam logic [ADDR_W-1:0] ACCEL_Z_HIGH_ADDR = 7'h1A;
    localparam logic [ADDR_W-1:0] FIRST_ADDR = RATE_X_LOW_ADDR;
    localparam logic [ADDR_W-1:0] LAST_ADDR = 7'h1B;

    // ========================================================
    // values after reset and fixed formats
    localparam logic [WORD_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = '0;
    localparam logic [WORD_W-1:0] UNMAPPED_READ = 16'h0000;
    localparam logic [WORD_W-1:0] ACCEL_POS_FS = 16'h7D00;
    localparam logic [WORD_W-1:0] ACCEL_NEG_FS = 16'h8300;

    // ========================================================
    // rate range variants and scale factors in counts per deg/s
    localparam logic [1:0] RANGE_125 = 2'h0;
    localparam logic [1:0] RANGE_500 = 2'h1;
    localparam logic [1:0] RANGE_2000 = 2'h2;
    localparam logic [7:0] SCALE_125 = 8'hA0;
    localparam logic [7:0] SCALE_500 = 8'h28;
    localparam logic [7:0] SCALE_2000 = 8'h0A;
endpackage : imu_out_pkg

// File: imu_sample_fifo.sv
/*
 * Sample buffer: synchronous FIFO, width and depth as parameters,
 * valid/ready on both sides. Assumes one clock and a clock enable.
 */
`timescale 1ns/100ps
`default_nettype none
module imu_sample_fifo
#(
    parameter int WIDTH = 192,
    parameter int DEPTH = 8
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW:0] wr_ptr_q, wr_ptr_d;
    logic [PW:0] rd_ptr_q, rd_ptr_d;
    logic push, pop, full, empty;

    // ========================================================
    // flags and pointers
    always_comb
    begin
        full = (wr_ptr_q[PW] != rd_ptr_q[PW]) && (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]);
        empty = (wr_ptr_q == rd_ptr_q);
        in_ready = !full;
        out_valid = !empty;
        push = ce && in_valid && !full;
        pop = ce && out_ready && !empty;
        wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
        out_data = mem_q[rd_ptr_q[PW-1:0]];
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
        end
    end

    // storage has no reset; contents are only read when valid
    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q[PW-1:0]] <= in_data;
        end
    end
endmodule : imu_sample_fifo
`default_nettype wire

// File: imu_host_model.sv
/*
 * Host model: reads output words over the register read port.
 * Assumes rd_valid and rd_data settle within 1 ns of the taking edge.
 */
`timescale 1ns/100ps
`default_nettype none
module imu_host_model
    import imu_out_pkg::*;
(
    input wire logic clock,
    output var logic rd_en,
    output var logic [ADDR_W-1:0] rd_addr,
    input wire logic rd_valid,
    input wire logic [WORD_W-1:0] rd_data
);
    initial
    begin
        rd_en = 1'b0;
        rd_addr = 7'h00;
    end

    // ====================================
    // single and paired word reads
    task automatic read_word(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d,
        output logic v);
        @(posedge clock);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        // idle address is not left holding the last value
        rd_addr <= ~a;
        #1;
        v = rd_valid;
        d = rd_data;
    endtask : read_word

    task automatic read_pair(input logic [ADDR_W-1:0] a, output logic [CHAN_W-1:0] s,
        output logic v);
        logic [WORD_W-1:0] lo;
        logic [WORD_W-1:0] hi;
        logic v0;
        read_word(a, lo, v0);
        read_word(a + 7'h02, hi, v);
        s = {hi, lo};
        v = v & v0;
    endtask : read_pair
endmodule : imu_host_model
`default_nettype wire

// File: tb_top.sv
/*
 * Testbench for the inertial output data registers.
 * Assumes the host model drives the read port; ce is high except in the freeze test.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin failures++; \
    $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
    import imu_out_pkg::*;
    typedef struct {logic [ADDR_W-1:0] addr; logic [CHAN_W-1:0] val;} row_s;
    logic clock = 1'b0, arst_n = 1'b0, sample_valid = 1'b0, update_tick = 1'b0;
    logic wr_en = 1'b0, ce = 1'b1, sample_ready, rd_en, rd_valid, wr_ignored;
    logic [1:0] range_sel = 2'h0;
    logic [7:0] rate_scale;
    logic [ADDR_W-1:0] rd_addr, wr_addr = 7'h00;
    logic [WORD_W-1:0] rd_data, w;
    logic [SAMPLE_W-1:0] smp = '0;
    logic [CHAN_W-1:0] s, k;
    logic v;
    int failures = 0, total_checks = 0, cycles = 0;
    row_s rows [6] = '{'{7'h04, 32'h4E20_1234}, '{7'h08, 32'hB1E0_0001},
        '{7'h0C, 32'h0000_0000}, '{7'h10, 32'h7D00_0000},
        '{7'h14, 32'h8300_0000}, '{7'h18, 32'hFFFF_FFFE}};

    inertial_output_data_regs i_inertial_output_data_regs (.clock(clock), .arst_n(arst_n),
        .ce(ce), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .rate_x_in(smp[191:160]), .rate_y_in(smp[159:128]), .rate_z_in(smp[127:96]),
        .accel_x_in(smp[95:64]), .accel_y_in(smp[63:32]), .accel_z_in(smp[31:0]),
        .update_tick(update_tick), .range_sel(range_sel), .rate_scale(rate_scale),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_ignored(wr_ignored));
    imu_host_model i_imu_host_model (.clock(clock), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_valid(rd_valid), .rd_data(rd_data));

    initial
    begin
        forever #2 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            test_done();
        end
    end

    // ====================================
    // helpers
    task automatic push(input logic [SAMPLE_W-1:0] x);
        @(posedge clock);
        sample_valid <= 1'b1;
        smp <= x;
        @(posedge clock);
        sample_valid <= 1'b0;
    endtask : push

    task automatic tick();
        @(posedge clock);
        update_tick <= 1'b1;
        @(posedge clock);
        update_tick <= 1'b0;
    endtask : tick

    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // ====================================
    // main sequence
    initial
    begin
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        #1;
        `CHECK("scale_rst", 8'hA0, rate_scale)
        `CHECK("ready_rst", 1'b1, sample_ready)
        i_imu_host_model.read_word(RATE_X_HIGH_ADDR, w, v);
        `CHECK("rst_word", 16'h0000, w)
        push({rows[0].val, rows[1].val, rows[2].val, rows[3].val, rows[4].val, rows[5].val});
        tick();
        for (int i = 0; i < 6; i++)
        begin
            i_imu_host_model.read_pair(rows[i].addr, s, v);
            `CHECK("pair", rows[i].val, s)
            `CHECK("pair_valid", 1'b1, v)
        end
        i_imu_host_model.read_word(7'h1C, w, v);
        `CHECK("unmapped", 16'h0000, w)
        `CHECK("unmapped_valid", 1'b1, v)
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock);
            range_sel <= 2'(i);
            @(posedge clock);
            #1;
            `CHECK("scale", i == 0 ? 8'hA0 : i == 1 ? 8'h28 : 8'h0A, rate_scale)
        end
        @(posedge clock);
        wr_en <= 1'b1;
        wr_addr <= RATE_X_HIGH_ADDR;
        #1;
        `CHECK("wr_ign", 1'b1, wr_ignored)
        @(posedge clock);
        wr_addr <= 7'h30;
        #1;
        `CHECK("wr_out", 1'b0, wr_ignored)
        @(posedge clock);
        wr_en <= 1'b0;
        i_imu_host_model.read_word(RATE_X_HIGH_ADDR, w, v);
        `CHECK("wr_keep", 16'h4E20, w)
        @(posedge clock);
        ce <= 1'b0;
        i_imu_host_model.read_word(RATE_Y_HIGH_ADDR, w, v);
        `CHECK("freeze_valid", 1'b0, v)
        `CHECK("freeze_data", 16'h4E20, w)
        @(posedge clock);
        ce <= 1'b1;
        i_imu_host_model.read_word(7'h05, w, v);
        `CHECK("odd_byte", 16'h1234, w)
        for (int j = 1; j <= 8; j++)
            push({6{16'hA000 | 16'(j), 16'(j)}});
        #1;
        `CHECK("full", 1'b0, sample_ready)
        push({6{32'h5555_5555}});
        #1;
        `CHECK("still_full", 1'b0, sample_ready)
        for (int j = 1; j <= 9; j++)
        begin
            tick();
            k = {16'hA000 | 16'(j > 8 ? 8 : j), 16'(j > 8 ? 8 : j)};
            i_imu_host_model.read_pair(RATE_X_LOW_ADDR, s, v);
            `CHECK("fifo_rate", k, s)
            i_imu_host_model.read_pair(7'h18, s, v);
            `CHECK("fifo_accel", k, s)
        end
        @(posedge clock);
        arst_n <= 1'b0;
        @(posedge clock);
        arst_n <= 1'b1;
        #1;
        `CHECK("rst2_scale", 8'hA0, rate_scale)
        `CHECK("rst2_ready", 1'b1, sample_ready)
        i_imu_host_model.read_word(RATE_X_LOW_ADDR, w, v);
        `CHECK("rst2_word", 16'h0000, w)
        test_done();
    end
endmodule : tb_top
`default_nettype wire
